// >>> gio_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit register words on a byte-addressed bus
// Notes:   Definitions only; shared by the cell and its delay counter
`ifndef GIO_REGS_SVH
`define GIO_REGS_SVH

// Register byte offsets
`define GIO_CTRL_OFS      8'h00
`define GIO_STAT_OFS      8'h04

// Control word fields
`define GIO_F_FAST        0
`define GIO_F_DIFF        1
`define GIO_F_MODE_LO     2
`define GIO_F_MODE_HI     3
`define GIO_F_RX_REG      4
`define GIO_F_TX_REG      5
`define GIO_F_OE_REG      6
`define GIO_F_RX_NEG      7
`define GIO_F_TX_NEG      8
`define GIO_F_OE_NEG      9
`define GIO_F_INVERT      10
`define GIO_F_RESYNC      11
`define GIO_F_ROUTE_LO    12
`define GIO_F_ROUTE_HI    14
`define GIO_CTRL_RST      32'h0000_0071
`define GIO_CTRL_MASK     32'h0000_7fff

// Status word fields
`define GIO_S_DCOUNT_LO   0
`define GIO_S_DCOUNT_HI   5
`define GIO_S_PAD_P       8
`define GIO_S_PAD_N       9
`define GIO_S_OE_MISM     10
`define GIO_S_CFG_ERR     11

// Bus responses
`define GIO_RESP_OKAY     2'h0
`define GIO_RESP_SLVERR   2'h2

// Dynamic delay counter
`define GIO_DLY_INIT      6'h00
`define GIO_DLY_MIN       6'h00
`define GIO_DLY_MAX       6'h3f

// Delay settle time and its cycle count, rounded up
`define GIO_CLK_PERIOD_NS 40
`define GIO_DLY_APPLY_NS  5
`define GIO_DLY_APPLY_CYC \
  ((`GIO_DLY_APPLY_NS + `GIO_CLK_PERIOD_NS - 1) / `GIO_CLK_PERIOD_NS)

`endif

// >>> gio_pkg.sv
// Purpose: Types shared by the I/O cell logic
// Assumes: Nothing beyond the register header
// Notes:   Enumerations follow Gray steps along the usual order
package gio_pkg;

  // Data path mode; code 2'h2 is illegal
  typedef enum logic [1:0] {
    GIO_MODE_SINGLE = 2'h0,
    GIO_MODE_DUAL   = 2'h1,
    GIO_MODE_SERIAL = 2'h3
  } gio_mode_t;

  // Destination of the unregistered alternate input
  typedef enum logic [2:0] {
    GIO_RT_NONE     = 3'h0,
    GIO_RT_PLLREF   = 3'h1,
    GIO_RT_GLOBAL   = 3'h3,
    GIO_RT_REGIONAL = 3'h2,
    GIO_RT_PLLFB    = 3'h6,
    GIO_RT_VREF     = 3'h7
  } gio_route_t;

  // Register decode result
  typedef enum logic [1:0] {
    GIO_REG_NONE = 2'h0,
    GIO_REG_CTRL = 2'h1,
    GIO_REG_STAT = 2'h3
  } gio_reg_t;

  typedef logic [3:0] gio_word_t;
  typedef logic [5:0] gio_tap_t;

endpackage

// >>> gio_delay_ctr.sv
// Purpose: Dynamic input delay count with up/down step and clear
// Assumes: step_en is a one-cycle pulse on the receive clock edge
// Notes:   The tap reaches the delay line a fixed settle time later
`timescale 1ns/10ps
`default_nettype none
`include "gio_regs.svh"

module gio_delay_ctr (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Stepping controls
  input  wire logic             step_en,
  input  wire logic             adjust_en,
  input  wire logic             step_up,
  input  wire logic             clear,
  // Count and applied tap
  output var  gio_pkg::gio_tap_t count_q,
  output wire gio_pkg::gio_tap_t tap_q
);
  import gio_pkg::*;

  gio_tap_t stage_q [`GIO_DLY_APPLY_CYC];

  // Clear wins over stepping; ends saturate instead of wrapping
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= `GIO_DLY_INIT;
    end else if (clear) begin
      count_q <= `GIO_DLY_INIT;
    end else if (step_en && adjust_en) begin
      if (step_up && count_q != `GIO_DLY_MAX) begin
        count_q <= count_q + 6'h01;
      end else if (!step_up && count_q != `GIO_DLY_MIN) begin
        count_q <= count_q - 6'h01;
      end
    end
  end

  // Settle pipeline: the delay line sees the new count later
  genvar g;
  generate
    for (g = 0; g < `GIO_DLY_APPLY_CYC; g++) begin : g_stage
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          stage_q[g] <= `GIO_DLY_INIT;
        end else if (g == 0) begin
          stage_q[g] <= count_q;
        end else begin
          stage_q[g] <= stage_q[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  assign tap_q = stage_q[`GIO_DLY_APPLY_CYC - 1];

endmodule
`default_nettype wire

// >>> gio_cell.sv
// Purpose: Core-side logic of a programmable general-purpose I/O cell
// Assumes: Register and serial clocks arrive as levels sampled by
//          sys_clk; their edges become one-cycle enables
// Notes:   Configuration is held in a control word over AXI4-Lite
`timescale 1ns/10ps
`default_nettype none
`include "gio_regs.svh"

module gio_cell (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  // Fabric clocks, sampled as levels
  input  wire logic              tx_reg_clk,
  input  wire logic              rx_reg_clk,
  input  wire logic              tx_serial_clk,
  input  wire logic              rx_serial_clk,
  // Fabric data and enables
  input  wire gio_pkg::gio_word_t out_data,
  input  wire logic              drive_enable,
  input  wire logic              drive_enable_comp,
  output var  gio_pkg::gio_word_t in_data,
  // Dynamic delay control
  input  wire logic              delay_adjust_enable,
  input  wire logic              delay_step_up,
  input  wire logic              delay_count_clear,
  output wire gio_pkg::gio_tap_t  input_delay_tap,
  // Alternate input destinations
  output var  logic              bypass_input,
  output var  logic              global_clock_net,
  output var  logic              regional_clock_net,
  output var  logic              pll_ref_clock,
  output var  logic              pll_feedback_input,
  output var  logic              vref_input,
  // Pad side
  input  wire logic              pad_p_i,
  input  wire logic              pad_n_i,
  output var  logic              pad_p_o,
  output var  logic              pad_p_oe,
  output var  logic              pad_n_o,
  output var  logic              pad_n_oe
);
  import gio_pkg::*;

  logic [31:0] ctrl_q;
  logic [3:0]  clk_prev_q;
  logic [3:0]  clk_now;
  logic [3:0]  clk_rise;
  logic [3:0]  clk_fall;
  logic        fast_io_cell;
  logic        differential;
  logic        rx_registered;
  logic        tx_registered;
  logic        oe_registered;
  logic        rx_neg;
  logic        tx_neg;
  logic        oe_neg;
  logic        invert;
  logic        resync;
  logic        double_edge_mode;
  gio_mode_t   io_mode;
  gio_route_t  route;
  logic        cfg_err;
  logic        rx_act;
  logic        tx_act;
  logic        oe_act;
  logic        rx_hi_q;
  logic        rx_lo_q;
  gio_word_t   rx_shift_q;
  logic        tx_bit_q;
  logic        tx_lo_q;
  gio_word_t   tx_word_q;
  gio_word_t   tx_shift_q;
  logic        tx_load_q;
  logic        oe_q;
  logic        oe_mism_q;
  gio_tap_t    dly_count;
  logic        aw_held_q;
  logic [7:0]  aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_go;
  gio_reg_t    wr_sel;
  logic [31:0] stat_word;
  logic [31:0] rd_word;

  // Decode of a register address, shared by the read and write paths
  function automatic gio_reg_t reg_sel(input logic [7:0] addr);
    if (addr == `GIO_CTRL_OFS) begin
      reg_sel = GIO_REG_CTRL;
    end else if (addr == `GIO_STAT_OFS) begin
      reg_sel = GIO_REG_STAT;
    end else begin
      reg_sel = GIO_REG_NONE;
    end
  endfunction

  // A low-speed cell may only reach the PLL reference
  function automatic logic route_hit(input gio_route_t sel,
                                     input logic fast,
                                     input gio_route_t dest);
    route_hit = (sel == dest) && (fast || dest == GIO_RT_PLLREF);
  endfunction

  // Control word fields
  assign fast_io_cell  = ctrl_q[`GIO_F_FAST];
  assign differential  = ctrl_q[`GIO_F_DIFF] & fast_io_cell;
  assign rx_registered = ctrl_q[`GIO_F_RX_REG];
  assign tx_registered = ctrl_q[`GIO_F_TX_REG];
  assign oe_registered = ctrl_q[`GIO_F_OE_REG];
  assign rx_neg        = ctrl_q[`GIO_F_RX_NEG];
  assign tx_neg        = ctrl_q[`GIO_F_TX_NEG];
  assign oe_neg        = ctrl_q[`GIO_F_OE_NEG];
  assign invert        = ctrl_q[`GIO_F_INVERT];
  assign resync        = ctrl_q[`GIO_F_RESYNC];
  assign route = gio_route_t'(ctrl_q[`GIO_F_ROUTE_HI:`GIO_F_ROUTE_LO]);

  // The low-speed cell has no serializer, so it falls back to single
  always_comb begin
    io_mode = gio_mode_t'(ctrl_q[`GIO_F_MODE_HI:`GIO_F_MODE_LO]);
    if (!fast_io_cell && io_mode == GIO_MODE_SERIAL) begin
      io_mode = GIO_MODE_SINGLE;
    end
  end
  assign double_edge_mode = (io_mode == GIO_MODE_DUAL);
  assign cfg_err = (ctrl_q[`GIO_F_MODE_HI:`GIO_F_MODE_LO] == 2'h2)
                 | (!fast_io_cell && ctrl_q[`GIO_F_MODE_HI])
                 | (!fast_io_cell && route != GIO_RT_NONE
                    && route != GIO_RT_PLLREF);

  // Edge enables; order is tx reg, rx reg, tx serial, rx serial
  assign clk_now  = {rx_serial_clk, tx_serial_clk, rx_reg_clk, tx_reg_clk};
  assign clk_rise = clk_now & ~clk_prev_q;
  assign clk_fall = ~clk_now & clk_prev_q;
  assign rx_act   = rx_neg ? clk_fall[1] : clk_rise[1];
  assign tx_act   = tx_neg ? clk_fall[0] : clk_rise[0];
  assign oe_act   = oe_neg ? clk_fall[0] : clk_rise[0];

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      clk_prev_q <= 4'h0;
    end else begin
      clk_prev_q <= clk_now;
    end
  end

  // Raw samples on both receive edges and the serial shifter
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rx_hi_q    <= 1'h0;
      rx_lo_q    <= 1'h0;
      rx_shift_q <= 4'h0;
    end else begin
      if (clk_rise[1]) begin
        rx_hi_q <= pad_p_i;
      end
      if (clk_fall[1]) begin
        rx_lo_q <= pad_p_i;
      end
      if (clk_rise[3]) begin
        rx_shift_q <= {pad_p_i, rx_shift_q[3:1]};
      end
    end
  end

  // Word handed to the fabric, per data mode
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      in_data <= 4'h0;
    end else begin
      unique case (io_mode)
        GIO_MODE_SINGLE: begin
          if (rx_act || !rx_registered) begin
            in_data <= {3'h0, pad_p_i};
          end
        end
        GIO_MODE_DUAL: begin
          if (resync) begin
            // Both halves of one period leave together on rising edge
            if (clk_rise[1]) begin
              in_data <= {2'h0, rx_lo_q, rx_hi_q};
            end
          end else begin
            if (clk_rise[1]) begin
              in_data[0] <= pad_p_i;
            end
            if (clk_fall[1]) begin
              in_data[1] <= pad_p_i;
            end
          end
        end
        GIO_MODE_SERIAL: begin
          if (clk_rise[1]) begin
            in_data <= rx_shift_q;
          end
        end
        default: begin
          in_data <= 4'h0;
        end
      endcase
    end
  end

  // Parallel word for the serializer, reloaded on each rising transmit register edge
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tx_word_q  <= 4'h0;
      tx_shift_q <= 4'h0;
      tx_load_q  <= 1'h0;
    end else begin
      if (clk_rise[0]) begin
        tx_word_q <= out_data;
      end
      // A new word that lands on a shift edge still waits its turn
      tx_load_q <= clk_rise[0] | (tx_load_q & ~clk_rise[2]);
      if (clk_rise[2]) begin
        tx_shift_q <= tx_load_q ? {1'h0, tx_word_q[3:1]}
                                : {1'h0, tx_shift_q[3:1]};
      end
    end
  end

  // Bit bound for the pad, per data mode
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tx_bit_q <= 1'h0;
      tx_lo_q  <= 1'h0;
    end else begin
      unique case (io_mode)
        GIO_MODE_SINGLE: begin
          if (tx_act || !tx_registered) begin
            tx_bit_q <= out_data[0];
          end
        end
        GIO_MODE_DUAL: begin
          if (clk_rise[0]) begin
            tx_bit_q <= out_data[0];
            tx_lo_q  <= out_data[1];
          end else if (clk_fall[0]) begin
            tx_bit_q <= tx_lo_q;
          end
        end
        GIO_MODE_SERIAL: begin
          if (clk_rise[2]) begin
            tx_bit_q <= tx_load_q ? tx_word_q[0]
                                  : tx_shift_q[0];
          end
        end
        default: begin
          tx_bit_q <= 1'h0;
        end
      endcase
    end
  end

  // Drive enable, registered on the transmit clock when asked
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      oe_q      <= 1'h0;
      oe_mism_q <= 1'h0;
    end else begin
      if (oe_act || !oe_registered) begin
        oe_q <= drive_enable;
      end
      oe_mism_q <= differential & (drive_enable ^ drive_enable_comp);
    end
  end

  // Pad drivers; the N side only drives as the complement leg
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pad_p_o  <= 1'h0;
      pad_p_oe <= 1'h0;
      pad_n_o  <= 1'h0;
      pad_n_oe <= 1'h0;
    end else begin
      pad_p_o  <= tx_bit_q ^ invert;
      pad_p_oe <= oe_q;
      pad_n_o  <= differential & ~(tx_bit_q ^ invert);
      // Trusts the complementary enable to equal the main one
      pad_n_oe <= differential & oe_q;
    end
  end

  // Alternate input bypasses every user register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bypass_input       <= 1'h0;
      global_clock_net   <= 1'h0;
      regional_clock_net <= 1'h0;
      pll_ref_clock      <= 1'h0;
      pll_feedback_input <= 1'h0;
      vref_input         <= 1'h0;
    end else begin
      bypass_input       <= pad_p_i;
      pll_ref_clock      <= pad_p_i &
        route_hit(route, fast_io_cell, GIO_RT_PLLREF);
      global_clock_net   <= pad_p_i &
        route_hit(route, fast_io_cell, GIO_RT_GLOBAL);
      regional_clock_net <= pad_p_i &
        route_hit(route, fast_io_cell, GIO_RT_REGIONAL);
      pll_feedback_input <= pad_p_i &
        route_hit(route, fast_io_cell, GIO_RT_PLLFB);
      vref_input         <= pad_p_i &
        route_hit(route, fast_io_cell, GIO_RT_VREF);
    end
  end

  // Delay stepping runs on the receive register clock, fast cell only
  gio_delay_ctr u_delay (
    .clk       (sys_clk),
    .rst_n     (resetn),
    .step_en   (clk_rise[1]),
    .adjust_en (delay_adjust_enable & fast_io_cell),
    .step_up   (delay_step_up),
    .clear     (delay_count_clear),
    .count_q   (dly_count),
    .tap_q     (input_delay_tap)
  );

  // Status word built from live state
  always_comb begin
    stat_word = 32'h0;
    stat_word[`GIO_S_DCOUNT_HI:`GIO_S_DCOUNT_LO] = dly_count;
    stat_word[`GIO_S_PAD_P]   = pad_p_i;
    stat_word[`GIO_S_PAD_N]   = pad_n_i;
    stat_word[`GIO_S_OE_MISM] = oe_mism_q;
    stat_word[`GIO_S_CFG_ERR] = cfg_err;
  end

  // Write address channel; held until paired with its data
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      awready   <= 1'h0;
      aw_held_q <= 1'h0;
      aw_addr_q <= 8'h0;
    end else if (awvalid && awready) begin
      awready   <= 1'h0;
      aw_held_q <= 1'h1;
      aw_addr_q <= awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'h0;
    end else if (!aw_held_q && !bvalid) begin
      awready <= 1'h1;
    end
  end

  // Write data channel, taken in either order against the address
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wready   <= 1'h0;
      w_held_q <= 1'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      wready   <= 1'h0;
      w_held_q <= 1'h1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_go) begin
      w_held_q <= 1'h0;
    end else if (!w_held_q && !bvalid) begin
      wready <= 1'h1;
    end
  end

  assign wr_go  = aw_held_q & w_held_q & ~bvalid;
  assign wr_sel = reg_sel(aw_addr_q);

  // Control word with byte lanes; the status word ignores writes
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_q <= `GIO_CTRL_RST;
    end else if (wr_go && wr_sel == GIO_REG_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_q[b]) begin
          ctrl_q[b*8 +: 8] <= w_data_q[b*8 +: 8]
                            & 8'(`GIO_CTRL_MASK >> (b*8));
        end
      end
    end
  end

  // Write response; unmapped addresses answer with a slave error
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bvalid <= 1'h0;
      bresp  <= `GIO_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'h1;
      bresp  <= (wr_sel == GIO_REG_NONE) ? `GIO_RESP_SLVERR
                                         : `GIO_RESP_OKAY;
    end else if (bvalid && bready) begin
      bvalid <= 1'h0;
    end
  end

  // Read data selection
  always_comb begin
    unique case (reg_sel(araddr))
      GIO_REG_CTRL: rd_word = ctrl_q;
      GIO_REG_STAT: rd_word = stat_word;
      default:      rd_word = 32'h0;
    endcase
  end

  // Read channel; one read in flight, answered the cycle after take
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      arready <= 1'h0;
      rvalid  <= 1'h0;
      rdata   <= 32'h0;
      rresp   <= `GIO_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'h0;
      rvalid  <= 1'h1;
      rdata   <= rd_word;
      rresp   <= (reg_sel(araddr) == GIO_REG_NONE) ? `GIO_RESP_SLVERR
                                                   : `GIO_RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'h0;
    end else if (!rvalid) begin
      arready <= 1'h1;
    end
  end

endmodule
`default_nettype wire

// >>> gio_checker.sv
// Purpose: Port assertions for the I/O cell
// Assumes: One sys_clk domain, synchronous active-low reset
// Notes:   Mode-dependent pad timing is left to the bench
`timescale 1ns/10ps
`default_nettype none
module gio_checker (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // Register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // Pad, alternate path and delay
  input wire logic        pad_p_i,
  input wire logic        bypass_input,
  input wire logic        global_clock_net,
  input wire logic        delay_count_clear,
  input wire logic [5:0]  input_delay_tap
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Requests taken by the slave
  sequence s_wr_take;
    // Address and data taken together; a split take answers later
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  a_reset_quiet: assert property ($rose(resetn) |-> !bvalid && !rvalid)
    else $error("response busy after reset");
  a_read_answer: assert property (s_rd_take |=> rvalid)
    else $error("read answer late");
  a_read_holds: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_write_holds: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_write_answer: assert property (s_wr_take |-> ##[1:2] bvalid)
    else $error("write answer late");
  a_unmapped_err: assert property (
    (s_rd_take and (araddr > 8'h04)) |=> rresp == 2'h2)
    else $error("unmapped read not refused");
  a_bypass_delay: assert property (
    $past(resetn) && $past(resetn, 2) |-> bypass_input == $past(pad_p_i))
    else $error("bypass path not one cycle");
  a_route_pad: assert property (global_clock_net |-> $past(pad_p_i))
    else $error("route net without pad");
  a_clear_tap: assert property (
    delay_count_clear |-> ##2 input_delay_tap == 6'h00)
    else $error("tap not cleared");
endmodule
bind gio_cell gio_checker u_chk (.*);
`default_nettype wire

// >>> gio_pad_model.sv
// Purpose: Board signal at the two pads
// Assumes: The bench sets the board level
// Notes:   A released pad shows the board, never a stale drive
`timescale 1ns/10ps
`default_nettype none
module gio_pad_model (
  // Drive from the cell and board level
  input wire logic pad_p_o,
  input wire logic pad_p_oe,
  input wire logic pad_n_o,
  input wire logic pad_n_oe,
  input wire logic ext,
  // Pad levels back to the cell
  output var logic pad_p_i,
  output var logic pad_n_i
);
  // The negative pad carries the complement of the board level
  always_comb pad_p_i = pad_p_oe ? pad_p_o : ext;
  always_comb pad_n_i = pad_n_oe ? pad_n_o : ~ext;
endmodule
`default_nettype wire

// >>> fpga_io_cell_gpio_logic_tb.sv
// Purpose: Self-checking bench for the I/O cell
// Assumes: Fabric clocks are levels driven by the bench
// Notes:   Each fabric clock step is followed by three sys_clk edges
`timescale 1ns/10ps
`default_nettype none
module fpga_io_cell_gpio_logic_tb;
  import gio_pkg::*;
  typedef struct packed {
    logic [7:0] wa; logic [31:0] wd; logic [1:0] br;
    logic [7:0] ra; logic [1:0] rr; logic [31:0] rv;
  } gio_row_t;
  // Cell and pad model ports
  logic        sys_clk, resetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, ext;
  logic        tx_reg_clk, rx_reg_clk, tx_serial_clk, rx_serial_clk;
  logic        drive_enable, drive_enable_comp, delay_adjust_enable;
  logic        delay_step_up, delay_count_clear, bypass_input;
  logic        global_clock_net, regional_clock_net, pll_ref_clock;
  logic        pll_feedback_input, vref_input, pad_p_i, pad_n_i;
  logic        pad_p_o, pad_p_oe, pad_n_o, pad_n_oe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  gio_word_t   out_data, in_data;
  gio_tap_t    input_delay_tap;
  int          fails, comparisons;
  // Write to unmapped, read reset value; mask; unmapped read
  gio_row_t rows [3] = '{'{8'h08, 32'hffff, 2'h2, 8'h00, 2'h0, 32'h71},
    '{8'h00, '1, 2'h0, 8'h00, 2'h0, 32'h7fff},
    '{8'h00, 32'h71, 2'h0, 8'h0c, 2'h2, 32'h0}};
  gio_cell uut (.*);
  gio_pad_model pad (.*);
  always #20 sys_clk = ~sys_clk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Address and data offered together, each released once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  // One fabric clock step with a new board level; index 4 steps none
  task tog(input int i, input logic e);
    @(posedge sys_clk);
    ext <= e;
    case (i)
      0: tx_reg_clk <= ~tx_reg_clk;
      1: rx_reg_clk <= ~rx_reg_clk;
      2: tx_serial_clk <= ~tx_serial_clk;
      3: rx_serial_clk <= ~rx_serial_clk;
      default: ;
    endcase
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // Bounded run; the tests need a few hundred cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    close_out;
  end
  initial begin
    {sys_clk, awvalid, wvalid, bready, arvalid, rready, ext} = '0;
    {tx_reg_clk, rx_reg_clk, tx_serial_clk, rx_serial_clk} = '0;
    {drive_enable, drive_enable_comp, delay_adjust_enable} = '0;
    {delay_step_up, delay_count_clear, resetn} = '0;
    {awaddr, araddr, wdata, out_data} = '0;
    wstrb = 4'hf;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    foreach (rows[k]) begin
      wr(rows[k].wa, rows[k].wd);
      chk(rsp, rows[k].br);
      rd_reg(rows[k].ra);
      chk(rsp, rows[k].rr);
      chk(rd, rows[k].rv);
    end
    // Single input: rising receive edge only, transmit clock ignored
    tog(1, 1'b1);
    chk(in_data[0], 1'b1);
    tog(1, 1'b0);
    chk(in_data[0], 1'b1);
    tog(0, 1'b0);
    chk(in_data[0], 1'b1);
    tog(0, 1'b0);
    wr(8'h00, 32'h3071);
    tog(4, 1'b1);
    chk(global_clock_net, 1'b1);
    chk(pll_ref_clock, 1'b0);
    chk(bypass_input, 1'b1);
    // Low-speed cell may not reach the feedback net
    wr(8'h00, 32'h6070);
    tog(4, 1'b1);
    chk(pll_feedback_input, 1'b0);
    wr(8'h00, 32'h7071);
    tog(4, 1'b1);
    chk(vref_input, 1'b1);
    wr(8'h00, 32'h2071);
    tog(4, 1'b1);
    chk(regional_clock_net, 1'b1);
    // Double-edge input: falling sample lands on bit one
    wr(8'h00, 32'h75);
    tog(1, 1'b0);
    tog(1, 1'b1);
    chk(in_data[1:0], 2'b10);
    // Resync: both halves handed over together on the rising edge
    wr(8'h00, 32'h875);
    tog(1, 1'b1);
    tog(1, 1'b0);
    tog(1, 1'b0);
    chk(in_data[1:0], 2'b01);
    // Deserializer, bit zero first
    wr(8'h00, 32'h7d);
    for (int k = 0; k < 4; k++) begin
      tog(3, 4'b1101 >> k);
      tog(3, 4'b1101 >> k);
    end
    tog(1, 1'b0);
    tog(1, 1'b0);
    chk(in_data, 4'b1101);
    // Delay steps: floor, two up, clear
    wr(8'h00, 32'h71);
    @(posedge sys_clk) delay_adjust_enable <= 1'b1;
    repeat (2) tog(1, 1'b0);
    chk(input_delay_tap, 6'h00);
    @(posedge sys_clk) delay_step_up <= 1'b1;
    repeat (4) tog(1, 1'b0);
    chk(input_delay_tap, 6'h02);
    rd_reg(8'h04);
    chk(rd[5:0], 6'h02);
    @(posedge sys_clk) delay_count_clear <= 1'b1;
    tog(4, 1'b0);
    chk(input_delay_tap, 6'h00);
    @(posedge sys_clk) delay_count_clear <= 1'b0;
    // Output path; both enables driven alike
    drive_enable <= 1'b1;
    drive_enable_comp <= 1'b1;
    out_data <= 4'b1110;
    tog(0, 1'b0);
    chk(pad_p_o, 1'b0);
    chk(pad_p_oe, 1'b1);
    wr(8'h00, 32'h473);
    repeat (2) tog(0, 1'b0);
    chk(pad_p_o, 1'b1);
    chk({pad_n_o, pad_n_oe}, 2'b01);
    wr(8'h00, 32'h75);
    out_data <= 4'b0001;
    repeat (2) tog(0, 1'b0);
    chk(pad_p_o, 1'b1);
    tog(0, 1'b0);
    chk(pad_p_o, 1'b0);
    // Serializer, bit zero first on its own clock
    wr(8'h00, 32'h7d);
    out_data <= 4'b0110;
    repeat (2) tog(0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      tog(2, 1'b0);
      chk(pad_p_o, 4'b0110 >> k & 1);
      tog(2, 1'b0);
    end
    // Mid-run reset drops the drive and restores the control word
    @(posedge sys_clk) resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    chk(pad_p_oe, 1'b0);
    rd_reg(8'h00);
    chk(rd, 32'h71);
    close_out;
  end
endmodule
`default_nettype wire
